// [core/nv_cfg_pkg.sv]
`default_nettype none
package nv_cfg_pkg;

    // bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    localparam int CNT_W  = 20;

    // clock
    localparam longint unsigned CLK_HZ  = 100_000_000;
    localparam longint unsigned CLK_MHZ = CLK_HZ / 1_000_000;

    // register indices and byte addresses (byte address is four times the index)
    localparam logic [7:0]        IDX_ADDR  = 8'hC6;
    localparam logic [7:0]        IDX_PWM   = 8'hC7;
    localparam logic [7:0]        IDX_TMO   = 8'hC8;
    localparam logic [7:0]        IDX_DIAG  = 8'hC9;
    localparam logic [7:0]        IDX_STAT  = 8'hD0;
    localparam logic [ADDR_W-1:0] ADDR_ADDR = {2'h0, IDX_ADDR, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PWM  = {2'h0, IDX_PWM, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_TMO  = {2'h0, IDX_TMO, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DIAG = {2'h0, IDX_DIAG, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};

    // reset values
    localparam logic [3:0] RST_ADDR = 4'h0;
    localparam logic [7:0] RST_PWM  = 8'hA7;
    localparam logic [6:0] RST_TMO  = 7'h03;
    localparam logic [7:0] RST_DIAG = 8'h00;

    // field positions
    localparam int FREQ_LSB    = 4;
    localparam int INTADDR_BIT = 3;
    localparam int OFAF_BIT    = 2;
    localparam int REF_LSB     = 0;
    localparam int TMO_LSB     = 4;
    localparam int SUP_LSB     = 0;
    localparam int ODI_LSB     = 4;
    localparam int ODPW_LSB    = 0;
    localparam int STAT_STRAP_LSB = 4;

    // decode constants
    localparam logic [9:0] REF_RATIO_BASE   = 10'h040;
    localparam logic [4:0] SUP_BASE_VOLTS   = 5'h05;
    localparam logic [5:0] ODI_OFFSET       = 6'h01;
    localparam logic [3:0] ODI_CHANNEL_CODE = 4'hF;
    localparam int         NUM_CHANNELS     = 12;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // dimming frequencies in tenths of Hz
    localparam longint unsigned PWM_FREQ_DHZ [16] = '{
        2000, 2500, 3000, 3500, 4000, 5000, 6000, 8000,
        10000, 12000, 20000, 40000, 59000, 78000, 96000, 208000};
    // bus timeouts in microseconds
    localparam longint unsigned TIMEOUT_US [8] = '{
        1000, 125, 250, 500, 1250, 2500, 5000, 10000};
    // diagnostic pulse widths in microseconds
    localparam longint unsigned PULSE_US [16] = '{
        100, 20, 30, 50, 80, 150, 200, 300,
        500, 800, 1000, 1200, 1500, 2000, 3000, 5000};

    typedef logic [CNT_W-1:0] count_t;

endpackage : nv_cfg_pkg
`default_nettype wire

// [core/nv_cfg_timing.sv]
`timescale 1ns/1ps
`default_nettype none
module nv_cfg_timing
    import nv_cfg_pkg::*;
#(
    parameter int unsigned CYCLE_DIV = 1
)
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    // codes
    input  wire logic [3:0]        freq_code_in,
    input  wire logic [2:0]        timeout_code_in,
    input  wire logic [3:0]        pulse_code_in,
    // cycle counts
    output var  nv_cfg_pkg::count_t pwm_period_cycles_out,
    output var  nv_cfg_pkg::count_t bus_timeout_cycles_out,
    output var  nv_cfg_pkg::count_t test_pulse_cycles_out
);

    // divide for short simulations, never below one cycle
    function automatic count_t scale(input longint unsigned cyc);
        longint unsigned q;
        q = cyc / CYCLE_DIV;
        if (q == 0)
            q = 1;
        return count_t'(q);
    endfunction : scale

    count_t pwm_rom [16];
    count_t tmo_rom [8];
    count_t pls_rom [16];

    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_rom16
            assign pwm_rom[g] = scale((CLK_HZ * 10) / PWM_FREQ_DHZ[g]);
            assign pls_rom[g] = scale(PULSE_US[g] * CLK_MHZ);
        end
        for (g = 0; g < 8; g++)
        begin : g_rom8
            assign tmo_rom[g] = scale(TIMEOUT_US[g] * CLK_MHZ);
        end
    endgenerate

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            pwm_period_cycles_out  <= '0;
            bus_timeout_cycles_out <= '0;
            test_pulse_cycles_out  <= '0;
        end
        else
        begin
            pwm_period_cycles_out  <= pwm_rom[freq_code_in];
            bus_timeout_cycles_out <= tmo_rom[timeout_code_in];
            test_pulse_cycles_out  <= pls_rom[pulse_code_in];
        end
    end

endmodule : nv_cfg_timing
`default_nettype wire

// [core/nonvolatile_default_config_bank.sv]
// What this block does
// - 4-bit code selects dimming PWM frequency, 200 Hz to 20.8 kHz, default 10.
// - Address source bit 0 uses strap pins, 1 uses stored address; default 0.
// - Failure mode 0 keeps others on, 1 turns all off; default 1.
// - 2-bit code selects reference ratio 64, 128, 256, 512; default 3.
// - 3-bit code selects bus timeout, 125 us to 10 ms; default 0.
// - Supply threshold is 5 plus code volts; default code 3, 8 V.
// - Test current codes 0-14 give (code*4+1)/64; 15 uses channel current.
// - 4-bit code selects diagnostic pulse width, 20 us to 5 ms; default 0.
// - Reset values A7, 03, 00 at consecutive offsets C7 to C9.
// - Bit 7 of timeout register reads zero, writes ignored.
// - Stored address is 4 bits in bits 3-0 of preceding register.
`timescale 1ns/1ps
`default_nettype none
module nonvolatile_default_config_bank
    import nv_cfg_pkg::*;
#(
    parameter int unsigned CYCLE_DIV = 1
)
(
    // clock and reset
    input  wire logic                                clk_in,
    input  wire logic                                rst_n_in,
    // axi4-lite write address
    input  wire logic [nv_cfg_pkg::ADDR_W-1:0]       awaddr_in,
    input  wire logic                                awvalid_in,
    output var  logic                                awready_out,
    // axi4-lite write data
    input  wire logic [nv_cfg_pkg::DATA_W-1:0]       wdata_in,
    input  wire logic [nv_cfg_pkg::STRB_W-1:0]       wstrb_in,
    input  wire logic                                wvalid_in,
    output var  logic                                wready_out,
    // axi4-lite write response
    output var  logic [1:0]                          bresp_out,
    output var  logic                                bvalid_out,
    input  wire logic                                bready_in,
    // axi4-lite read address
    input  wire logic [nv_cfg_pkg::ADDR_W-1:0]       araddr_in,
    input  wire logic                                arvalid_in,
    output var  logic                                arready_out,
    // axi4-lite read data
    output var  logic [nv_cfg_pkg::DATA_W-1:0]       rdata_out,
    output var  logic [1:0]                          rresp_out,
    output var  logic                                rvalid_out,
    input  wire logic                                rready_in,
    // strap pins and channel faults
    input  wire logic                                address_strap_2_in,
    input  wire logic                                address_strap_1_in,
    input  wire logic                                address_strap_0_in,
    input  wire logic [nv_cfg_pkg::NUM_CHANNELS-1:0] channel_fault_in,
    // dimming
    output var  logic [3:0]                          dim_frequency_code_out,
    output var  nv_cfg_pkg::count_t                  pwm_period_cycles_out,
    // addressing
    output var  logic                                address_source_select_out,
    output var  logic [3:0]                          bus_address_out,
    // failure handling
    output var  logic                                failure_spread_mode_out,
    output var  logic [nv_cfg_pkg::NUM_CHANNELS-1:0] channel_off_out,
    // reference current
    output var  logic [1:0]                          reference_ratio_code_out,
    output var  logic [9:0]                          reference_ratio_out,
    // bus timeout
    output var  logic [2:0]                          bus_timeout_code_out,
    output var  nv_cfg_pkg::count_t                  bus_timeout_cycles_out,
    // supply monitor
    output var  logic [3:0]                          supply_threshold_code_out,
    output var  logic [4:0]                          supply_threshold_volts_out,
    // on-demand diagnostics
    output var  logic [3:0]                          test_current_code_out,
    output var  logic [5:0]                          test_current_num_out,
    output var  logic                                test_use_channel_current_out,
    output var  logic [3:0]                          test_pulse_width_code_out,
    output var  nv_cfg_pkg::count_t                  test_pulse_cycles_out
);

    // register contents
    logic [3:0] stored_bus_address;
    logic [7:0] pwm_cfg;
    logic [6:0] tmo_cfg;
    logic [7:0] diag_cfg;

    // write channel holding
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic              do_write;

    // field views
    logic [3:0] freq_code;
    logic [2:0] timeout_code;
    logic [3:0] pulse_code;
    logic [2:0] strap_addr;
    logic [3:0] next_bus_address;

    // which register a byte address hits
    typedef enum {SEL_NONE, SEL_ADDR, SEL_PWM, SEL_TMO, SEL_DIAG, SEL_STAT} reg_sel_t;

    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        case (addr)
            ADDR_ADDR: return SEL_ADDR;
            ADDR_PWM:  return SEL_PWM;
            ADDR_TMO:  return SEL_TMO;
            ADDR_DIAG: return SEL_DIAG;
            ADDR_STAT: return SEL_STAT;
            default:   return SEL_NONE;
        endcase
    endfunction : decode

    assign freq_code    = pwm_cfg[FREQ_LSB +: 4];
    assign timeout_code = tmo_cfg[TMO_LSB +: 3];
    assign pulse_code   = diag_cfg[ODPW_LSB +: 4];
    assign strap_addr   = {address_strap_2_in, address_strap_1_in, address_strap_0_in};
    assign do_write     = aw_held && w_held && !bvalid_out;

    always_comb
    begin
        if (pwm_cfg[INTADDR_BIT])
            next_bus_address = stored_bus_address;
        else
            next_bus_address = {1'b0, strap_addr};
    end

    // write address accept, any order against data
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end
        else if (awvalid_in && awready_out)
        begin
            aw_held <= 1'b1;
            aw_addr <= awaddr_in;
        end
        else if (do_write)
        begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            awready_out <= 1'b0;
        else
            awready_out <= !aw_held && !(awvalid_in && awready_out) && !bvalid_out && !do_write;
    end

    // write data accept
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end
        else if (wvalid_in && wready_out)
        begin
            w_held <= 1'b1;
            w_data <= wdata_in;
            w_strb <= wstrb_in;
        end
        else if (do_write)
        begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            wready_out <= 1'b0;
        else
            wready_out <= !w_held && !(wvalid_in && wready_out) && !bvalid_out && !do_write;
    end

    // write response
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            bvalid_out <= 1'b0;
            bresp_out  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_out <= 1'b1;
            bresp_out  <= (decode(aw_addr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (bready_in)
        begin
            bvalid_out <= 1'b0;
        end
    end

    // register storage, low byte lane only
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            stored_bus_address <= RST_ADDR;
            pwm_cfg            <= RST_PWM;
            tmo_cfg            <= RST_TMO;
            diag_cfg           <= RST_DIAG;
        end
        else if (do_write && w_strb[0])
        begin
            case (decode(aw_addr))
                SEL_ADDR: stored_bus_address <= w_data[3:0];
                SEL_PWM:  pwm_cfg <= w_data[7:0];
                SEL_TMO:  tmo_cfg <= w_data[6:0];
                SEL_DIAG: diag_cfg <= w_data[7:0];
                default:  ;
            endcase
        end
    end

    // read channel, answer one cycle after address taken
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            arready_out <= 1'b0;
        else
            arready_out <= !rvalid_out && !(arvalid_in && arready_out);
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            rvalid_out <= 1'b0;
            rdata_out  <= '0;
            rresp_out  <= RESP_OKAY;
        end
        else if (arvalid_in && arready_out)
        begin
            rvalid_out <= 1'b1;
            rresp_out  <= RESP_OKAY;
            case (decode(araddr_in))
                SEL_ADDR: rdata_out <= DATA_W'(stored_bus_address);
                SEL_PWM:  rdata_out <= DATA_W'(pwm_cfg);
                SEL_TMO:  rdata_out <= DATA_W'(tmo_cfg);
                SEL_DIAG: rdata_out <= DATA_W'(diag_cfg);
                SEL_STAT: rdata_out <= DATA_W'({strap_addr, bus_address_out});
                default:
                begin
                    rdata_out <= '0;
                    rresp_out <= RESP_SLVERR;
                end
            endcase
        end
        else if (rready_in)
        begin
            rvalid_out <= 1'b0;
        end
    end

    // all selectors refreshed together each cycle
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            dim_frequency_code_out    <= RST_PWM[FREQ_LSB +: 4];
            reference_ratio_code_out  <= RST_PWM[REF_LSB +: 2];
            reference_ratio_out       <= REF_RATIO_BASE << RST_PWM[REF_LSB +: 2];
            bus_timeout_code_out      <= RST_TMO[TMO_LSB +: 3];
            supply_threshold_code_out <= RST_TMO[SUP_LSB +: 4];
            supply_threshold_volts_out <= SUP_BASE_VOLTS + 5'(RST_TMO[SUP_LSB +: 4]);
            test_pulse_width_code_out <= RST_DIAG[ODPW_LSB +: 4];
        end
        else
        begin
            dim_frequency_code_out    <= freq_code;
            // ratio is base shifted by code
            reference_ratio_code_out  <= pwm_cfg[REF_LSB +: 2];
            reference_ratio_out       <= REF_RATIO_BASE << pwm_cfg[REF_LSB +: 2];
            bus_timeout_code_out      <= timeout_code;
            supply_threshold_code_out <= tmo_cfg[SUP_LSB +: 4];
            supply_threshold_volts_out <= SUP_BASE_VOLTS + 5'(tmo_cfg[SUP_LSB +: 4]);
            test_pulse_width_code_out <= pulse_code;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            test_current_code_out        <= RST_DIAG[ODI_LSB +: 4];
            test_current_num_out         <= ODI_OFFSET;
            test_use_channel_current_out <= 1'b0;
        end
        else
        begin
            test_current_code_out        <= diag_cfg[ODI_LSB +: 4];
            test_current_num_out         <= {diag_cfg[ODI_LSB +: 4], 2'h0} + ODI_OFFSET;
            test_use_channel_current_out <= (diag_cfg[ODI_LSB +: 4] == ODI_CHANNEL_CODE);
        end
    end

    // address selection outputs
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            address_source_select_out <= RST_PWM[INTADDR_BIT];
            bus_address_out           <= '0;
        end
        else
        begin
            address_source_select_out <= pwm_cfg[INTADDR_BIT];
            bus_address_out           <= next_bus_address;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            failure_spread_mode_out <= RST_PWM[OFAF_BIT];
        else
            failure_spread_mode_out <= pwm_cfg[OFAF_BIT];
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch++)
        begin : g_chan
            always_ff @(posedge clk_in)
            begin
                if (!rst_n_in)
                    channel_off_out[ch] <= 1'b0;
                else
                    channel_off_out[ch] <= channel_fault_in[ch]
                                           || (pwm_cfg[OFAF_BIT] && (|channel_fault_in));
            end
        end
    endgenerate

    // cycle counts for timed settings
    nv_cfg_timing #(
        .CYCLE_DIV (CYCLE_DIV)
    ) u_timing (
        .clk_in                 (clk_in),
        .rst_n_in               (rst_n_in),
        .freq_code_in           (freq_code),
        .timeout_code_in        (timeout_code),
        .pulse_code_in          (pulse_code),
        .pwm_period_cycles_out  (pwm_period_cycles_out),
        .bus_timeout_cycles_out (bus_timeout_cycles_out),
        .test_pulse_cycles_out  (test_pulse_cycles_out)
    );

endmodule : nonvolatile_default_config_bank
`default_nettype wire

// [tb/nv_cfg_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module nv_cfg_checker
    import nv_cfg_pkg::*;
(
    // clock, reset and bus handshakes
    input  wire logic                                clk_in,
    input  wire logic                                rst_n_in,
    input  wire logic                                awvalid_in,
    input  wire logic                                awready_out,
    input  wire logic                                wvalid_in,
    input  wire logic                                wready_out,
    input  wire logic [1:0]                          bresp_out,
    input  wire logic                                bvalid_out,
    input  wire logic                                bready_in,
    input  wire logic                                arvalid_in,
    input  wire logic                                arready_out,
    input  wire logic [nv_cfg_pkg::DATA_W-1:0]       rdata_out,
    input  wire logic                                rvalid_out,
    input  wire logic                                rready_in,
    // straps and faults
    input  wire logic                                address_strap_2_in,
    input  wire logic                                address_strap_1_in,
    input  wire logic                                address_strap_0_in,
    input  wire logic [nv_cfg_pkg::NUM_CHANNELS-1:0] channel_fault_in,
    // decoded settings
    input  wire logic [3:0]                          dim_frequency_code_out,
    input  wire logic                                address_source_select_out,
    input  wire logic [3:0]                          bus_address_out,
    input  wire logic                                failure_spread_mode_out,
    input  wire logic [nv_cfg_pkg::NUM_CHANNELS-1:0] channel_off_out,
    input  wire logic [1:0]                          reference_ratio_code_out,
    input  wire logic [9:0]                          reference_ratio_out,
    input  wire logic [3:0]                          supply_threshold_code_out,
    input  wire logic [4:0]                          supply_threshold_volts_out,
    input  wire logic [3:0]                          test_current_code_out,
    input  wire logic [5:0]                          test_current_num_out,
    input  wire logic                                test_use_channel_current_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_wr_taken;
        awvalid_in && awready_out && wvalid_in && wready_out;
    endsequence
    sequence s_rd_taken;
        arvalid_in && arready_out;
    endsequence

    a_ratio_value: assert property (reference_ratio_out == (10'h040 << reference_ratio_code_out))
        else $error("ratio wrong");
    a_volts_value: assert property (supply_threshold_volts_out == 5'h05 + 5'(supply_threshold_code_out))
        else $error("volts wrong");
    a_current_num: assert property (test_current_num_out == {test_current_code_out, 2'h1})
        else $error("numerator wrong");
    a_channel_use: assert property (test_use_channel_current_out == (test_current_code_out == 4'hF))
        else $error("channel use wrong");
    a_strap_addr: assert property ($past(rst_n_in) && !address_source_select_out
        |-> bus_address_out == $past({1'b0, address_strap_2_in, address_strap_1_in, address_strap_0_in}))
        else $error("strap address wrong");
    a_fail_spread: assert property ($past(rst_n_in) |-> channel_off_out ==
        ($past(channel_fault_in) | {NUM_CHANNELS{failure_spread_mode_out && (|$past(channel_fault_in))}}))
        else $error("off pattern wrong");
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] bvalid_out)
        else $error("no bresp");
    a_read_answer: assert property (s_rd_taken |=> rvalid_out)
        else $error("no rdata");
    a_resp_held: assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
        else $error("bresp dropped");
    a_data_held: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
        else $error("rdata dropped");
    a_reset_load: assert property (disable iff (1'b0) !rst_n_in |=> dim_frequency_code_out == 4'hA
        && !address_source_select_out && failure_spread_mode_out && reference_ratio_code_out == 2'h3
        && supply_threshold_code_out == 4'h3 && test_current_code_out == 4'h0 && !bvalid_out && !rvalid_out)
        else $error("reset wrong");
endmodule : nv_cfg_checker

bind nonvolatile_default_config_bank nv_cfg_checker checker_u (.*);
`default_nettype wire

// [tb/nonvolatile_default_config_bank_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module nonvolatile_default_config_bank_bench;
    import nv_cfg_pkg::*;
    localparam int unsigned DIV = 100;
    logic                    clk_in = 1'b0, rst_n_in = 1'b0;
    logic [ADDR_W-1:0]       awaddr = '0, araddr = '0;
    logic                    awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [DATA_W-1:0]       wdata = '0, rdata;
    logic [STRB_W-1:0]       wstrb = '0;
    logic [2:0]              strap = '0, tcode;
    logic [NUM_CHANNELS-1:0] fault = '0, off;
    logic                    awready, wready, bvalid, arready, rvalid, sel, mode, cuse;
    logic [1:0]              bresp, rresp, rcode, wq [$];
    logic [3:0]              dim_code, bus_addr, scode, ccode, pcode;
    logic [9:0]              ratio;
    logic [4:0]              volts;
    logic [5:0]              cnum;
    count_t                  tcyc, pcyc, wcyc;
    logic [7:0]              m [4];
    logic [33:0]             rq [$];
    integer                  seed = 32'h2ea2;
    int                      failures = 0, num_checks = 0, cycles = 0;

    always #5 clk_in = ~clk_in;

    nonvolatile_default_config_bank #(.CYCLE_DIV(DIV)) dut_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in),
        .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
        .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid), .wready_out(wready),
        .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
        .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready),
        .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready),
        .address_strap_2_in(strap[2]), .address_strap_1_in(strap[1]), .address_strap_0_in(strap[0]),
        .channel_fault_in(fault), .dim_frequency_code_out(dim_code), .pwm_period_cycles_out(wcyc),
        .address_source_select_out(sel), .bus_address_out(bus_addr),
        .failure_spread_mode_out(mode), .channel_off_out(off),
        .reference_ratio_code_out(rcode), .reference_ratio_out(ratio),
        .bus_timeout_code_out(tcode), .bus_timeout_cycles_out(tcyc),
        .supply_threshold_code_out(scode), .supply_threshold_volts_out(volts),
        .test_current_code_out(ccode), .test_current_num_out(cnum),
        .test_use_channel_current_out(cuse), .test_pulse_width_code_out(pcode), .test_pulse_cycles_out(pcyc));

    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    task automatic check(input string name, logic [33:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    always @(posedge clk_in)
    begin
        if (bvalid && bready && wq.size())
            check("bresp", 34'(bresp), 34'(wq.pop_front()));
        if (rvalid && rready && rq.size())
            check("read", {rresp, rdata}, rq.pop_front());
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            finish_test();
        end
    end

    task automatic do_reset();
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        m = '{8'h00, 8'hA7, 8'h03, 8'h00};
    endtask : do_reset

    task automatic wr(input logic [ADDR_W-1:0] a, logic [7:0] d, logic [3:0] s, logic [1:0] er);
        wq.push_back(er);
        @(posedge clk_in);
        {awaddr, awvalid, wvalid, bready} <= {a, 3'h7};
        wdata <= {24'($random(seed)), d};
        wstrb <= s;
        while (awvalid || wvalid || !(bvalid && bready))
        begin
            @(posedge clk_in);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, logic [33:0] e);
        rq.push_back(e);
        @(posedge clk_in);
        {araddr, arvalid, rready} <= {a, 2'h3};
        while (arvalid || !(rvalid && rready))
        begin
            @(posedge clk_in);
            if (arready)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : rd

    task automatic rd_all();
        for (int i = 0; i < 4; i++)
            rd(ADDR_ADDR + 12'(4 * i), {RESP_OKAY, 24'h0, m[i]});
        rd(ADDR_STAT, {RESP_OKAY, 25'h0, strap, m[1][3] ? m[0][3:0] : {1'b0, strap}});
    endtask : rd_all

    task automatic chk_out();
        logic [7:0] p, t, g;
        p = m[1];
        t = m[2];
        g = m[3];
        repeat (2) @(posedge clk_in);
        #1;
        check("freq", 34'(dim_code), 34'(p[7:4]));
        check("pwmcyc", 34'(wcyc), 34'(CLK_HZ * 10 / PWM_FREQ_DHZ[p[7:4]] / DIV));
        check("sel", 34'(sel), 34'(p[3]));
        check("addr", 34'(bus_addr), 34'(p[3] ? m[0][3:0] : {1'b0, strap}));
        check("mode", 34'(mode), 34'(p[2]));
        check("off", 34'(off), 34'(fault | {NUM_CHANNELS{p[2] & (|fault)}}));
        check("ratio", 34'(ratio), 34'(64 << p[1:0]));
        check("tmo", 34'(tcode), 34'(t[6:4]));
        check("tmocyc", 34'(tcyc), 34'(TIMEOUT_US[t[6:4]] * 100 / DIV));
        check("volts", 34'(volts), 34'(5 + t[3:0]));
        check("cur", 34'(ccode), 34'(g[7:4]));
        check("num", 34'(cnum), 34'(g[7:4] * 4 + 1));
        check("use", 34'(cuse), 34'(g[7:4] == 4'hF));
        check("pulse", 34'(pcode), 34'(g[3:0]));
        check("pcyc", 34'(pcyc), 34'(PULSE_US[g[3:0]] * 100 / DIV));
    endtask : chk_out

    initial
    begin
        do_reset();
        strap <= 3'($random(seed));
        chk_out();
        rd_all();
        for (int i = 0; i < 16; i++)
        begin
            strap <= 3'($random(seed));
            fault <= NUM_CHANNELS'($random(seed)) & {NUM_CHANNELS{i[0]}};
            m[0] = {4'h0, 4'($random(seed))};
            m[1] = {i[3:0], 4'(15 - i)};
            m[2] = {1'b0, i[2:0], 4'(15 - i)};
            m[3] = {i[3:0], 4'(i * 7)};
            wr(ADDR_ADDR, {4'($random(seed)), m[0][3:0]}, 4'h1, RESP_OKAY);
            wr(ADDR_PWM, m[1], 4'hF, RESP_OKAY);
            wr(ADDR_TMO, {1'b1, m[2][6:0]}, 4'h1, RESP_OKAY);
            wr(ADDR_DIAG, m[3], 4'h1, RESP_OKAY);
            chk_out();
            rd_all();
        end
        wr(ADDR_DIAG + 12'h004, 8'hFF, 4'hF, RESP_SLVERR);
        wr(ADDR_PWM, 8'h00, 4'hE, RESP_OKAY);
        rd(ADDR_DIAG + 12'h004, {RESP_SLVERR, 32'h0});
        rd_all();
        do_reset();
        chk_out();
        rd_all();
        finish_test();
    end
endmodule : nonvolatile_default_config_bank_bench
`default_nettype wire
